// *** common/bsfl_defs.svh ***
`ifndef BSFL_DEFS_SVH
`define BSFL_DEFS_SVH

// clock rates and serial clock timing
`define BSFL_MCLK_HZ       125000000
`define BSFL_SCK_HZ        12000000
// half period rounded up so the flash never sees more than its rated clock
`define BSFL_HALF_CYC      ((`BSFL_MCLK_HZ + 2 * `BSFL_SCK_HZ - 1) / (2 * `BSFL_SCK_HZ))

// flash read sequence
`define BSFL_CMD_READ      8'h03
`define BSFL_FLASH_BASE    24'h000000
`define BSFL_CMD_LAST      16'h0003
`define BSFL_BUNDLE_LAST   16'h00ff
`define BSFL_MAGIC         8'ha5
`define BSFL_IDX_MAGIC     16'h0000
`define BSFL_IDX_SWSEL     16'h0001

// strap sampling settle count after reset release
`define BSFL_STRAP_SETTLE  4'h3

// divider ratio thresholds in hundredths
`define BSFL_TH_20         7'h14
`define BSFL_TH_30         7'h1e
`define BSFL_TH_40         7'h28
`define BSFL_TH_50         7'h32
`define BSFL_TH_60         7'h3c
`define BSFL_TH_70         7'h46
`define BSFL_TH_80         7'h50
`define BSFL_TH_90         7'h5a

`endif

// *** common/bsfl_pkg.sv ***
package bsfl_pkg;

  typedef enum logic [2:0] {
    MODE_NO_RESPONSE,
    MODE_WAIT_3V3_INT,
    MODE_WAIT_3V3_EXT,
    MODE_CTRL_WAIT_INT,
    MODE_CTRL_WAIT_EXT,
    MODE_NO_WAIT
  } bsfl_mode_e;

  typedef enum logic [2:0] {
    CFG_SAFE,
    CFG_INFINITE_WAIT,
    CFG_3,
    CFG_5,
    CFG_RESERVED
  } bsfl_cfg_e;

  typedef enum logic [2:0] {
    ST_STRAP,
    ST_DECIDE,
    ST_WAIT3V3,
    ST_START,
    ST_CMD,
    ST_DATA,
    ST_FAIL,
    ST_RUN
  } bsfl_state_e;

  typedef struct packed {
    bsfl_mode_e mode;
    bsfl_cfg_e  cfg;
  } bsfl_strap_s;

  typedef struct packed {
    logic       busy;
    logic       sck;
    logic [3:0] div;
    logic [2:0] bits;
    logic [7:0] sh;
    logic [7:0] rx;
    logic       done;
    logic       mosi;
  } bsfl_spi_s;

  typedef struct packed {
    logic [1:0]  miso_sync;
    logic [1:0]  v3_sync;
    logic [3:0]  port_sync;
    bsfl_state_e st;
    logic [3:0]  settle;
    logic        strap_level;
    bsfl_mode_e  mode;
    bsfl_cfg_e   cfg;
    logic        cs_b;
    logic [15:0] idx;
    logic [1:0]  sw_sel;
    logic        loaded;
    logic        fallback;
    logic [7:0]  load_data;
    logic        load_valid;
    logic [1:0]  path_int;
    logic [1:0]  path_ext;
    logic        ports_en;
    logic        legacy_sink;
  } bsfl_boot_s;

endpackage : bsfl_pkg

// *** logic/bsfl_boot_loader.sv ***
// Functional notes
// - boot fetches patch and configuration content from the serial flash
// - serial clock runs at no more than 12 MHz; flash must support it
// - mode 0 only; first data bit appears as chip select falls
// - chip select low during a transfer, high otherwise
// - data changes on falling clock edge, sampled on rising edge
// - serial clock idles low outside transfers
// - at power-on run boot: init state, then load bundles
// - strap level on data-in pin and analog band pick boot behaviour
// - strap high: six bands map to modes; controller-wait gets infinite wait
// - strap low: bands give config 3, config 5, reserved, controller wait, or no-response
// - dead-battery mode only matters while powered from the bus
// - no-response: no switch closed, wait for 3.3 V before start-up
// - 3.3 V wait: close the selected path switch, then wait for 3.3 V
// - controller wait: close the selected path switch, retry load forever
// - no-wait: load from bus power, then close the loaded switch choice
// - try serial or alternate configuration first, else strap fallback
// - safe fallback disables ports; on bus power acts as legacy sink
// - infinite-wait fallback stays in boot until configuration arrives
`timescale 1ns/1ps
`default_nettype none
`include "bsfl_defs.svh"

module bsfl_boot_loader
  import bsfl_pkg::*;
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  // straps and supplies
  input  wire logic [6:0] i_strap_ratio,
  input  wire logic       i_strap_ratio_valid,
  input  wire logic       i_main_3v3_input,
  input  wire logic [1:0] i_powered_port,
  // alternate configuration path
  input  wire logic       i_alt_cfg_valid,
  input  wire logic [1:0] i_alt_switch_sel,
  // flash pins
  input  wire logic       i_flash_data_in,
  output logic            o_flash_clk,
  output logic            o_flash_cs_b,
  output logic            o_flash_data_out,
  // loaded content stream
  output logic [7:0]      o_load_data,
  output logic            o_load_valid,
  // boot status
  output bsfl_mode_e      o_mode,
  output bsfl_cfg_e       o_cfg,
  output logic            o_boot_done,
  output logic            o_cfg_loaded,
  output logic            o_fallback,
  // power path and port control
  output logic [1:0]      o_high_voltage_path_int_en,
  output logic [1:0]      o_high_voltage_path_ext_en,
  output logic            o_ports_en,
  output logic            o_legacy_sink
);

  bsfl_boot_s s_q;
  bsfl_boot_s s_d;

  logic       spi_go;
  logic [7:0] spi_tx;
  logic       spi_busy;
  logic       spi_done;
  logic [7:0] spi_rx;
  logic       bus_only;
  logic [1:0] port_pwr;
  logic [1:0] int_en;
  logic [1:0] ext_en;
  bsfl_strap_s strap;

  // band decode; gaps between bands fall to the band below
  function automatic bsfl_strap_s decode_strap(input logic lvl, input logic [6:0] r);
    bsfl_strap_s o;
    if (lvl) begin
      if (r < `BSFL_TH_20)      o = '{MODE_NO_RESPONSE,   CFG_SAFE};
      else if (r < `BSFL_TH_30) o = '{MODE_WAIT_3V3_INT,  CFG_SAFE};
      else if (r < `BSFL_TH_40) o = '{MODE_CTRL_WAIT_INT, CFG_INFINITE_WAIT};
      else if (r < `BSFL_TH_50) o = '{MODE_WAIT_3V3_EXT,  CFG_SAFE};
      else if (r < `BSFL_TH_60) o = '{MODE_CTRL_WAIT_EXT, CFG_INFINITE_WAIT};
      else                      o = '{MODE_NO_WAIT,       CFG_SAFE};
    end else begin
      if (r < `BSFL_TH_30)      o = '{MODE_NO_RESPONSE,   CFG_INFINITE_WAIT};
      else if (r < `BSFL_TH_40) o = '{MODE_CTRL_WAIT_INT, CFG_INFINITE_WAIT};
      else if (r < `BSFL_TH_50) o = '{MODE_NO_WAIT,       CFG_3};
      else if (r < `BSFL_TH_60) o = '{MODE_CTRL_WAIT_EXT, CFG_INFINITE_WAIT};
      else if (r < `BSFL_TH_70) o = '{MODE_NO_RESPONSE,   CFG_INFINITE_WAIT};
      else if (r < `BSFL_TH_80) o = '{MODE_NO_WAIT,       CFG_RESERVED};
      else if (r < `BSFL_TH_90) o = '{MODE_NO_RESPONSE,   CFG_INFINITE_WAIT};
      else                      o = '{MODE_NO_WAIT,       CFG_5};
    end
    return o;
  endfunction : decode_strap

  // read command followed by the three address bytes
  function automatic logic [7:0] cmd_byte(input logic [15:0] i);
    logic [7:0] b;
    if (i == 16'h0000)      b = `BSFL_CMD_READ;
    else if (i == 16'h0001) b = 8'(`BSFL_FLASH_BASE >> 16);
    else if (i == 16'h0002) b = 8'(`BSFL_FLASH_BASE >> 8);
    else                    b = 8'(`BSFL_FLASH_BASE);
    return b;
  endfunction : cmd_byte

  assign bus_only = !s_q.v3_sync[1];
  assign port_pwr = s_q.port_sync[3:2];
  assign strap    = decode_strap(s_q.miso_sync[1], i_strap_ratio);

  // per-port switch choice: strap mode while unloaded, loaded choice after
  genvar p;
  generate
    for (p = 0; p < 2; p++) begin : g_port
      assign int_en[p] = port_pwr[p] & (
        (s_q.loaded & s_q.sw_sel[0]) |
        (!s_q.loaded & bus_only & s_q.st != ST_STRAP &
         (s_q.mode == MODE_WAIT_3V3_INT || s_q.mode == MODE_CTRL_WAIT_INT)));
      assign ext_en[p] = port_pwr[p] & (
        (s_q.loaded & s_q.sw_sel[1]) |
        (!s_q.loaded & bus_only & s_q.st != ST_STRAP &
         (s_q.mode == MODE_WAIT_3V3_EXT || s_q.mode == MODE_CTRL_WAIT_EXT)));
    end
  endgenerate

  always_comb begin
    s_d            = s_q;
    spi_go         = 1'b0;
    spi_tx         = 8'h00;
    s_d.load_valid = 1'b0;
    s_d.miso_sync  = {s_q.miso_sync[0], i_flash_data_in};
    s_d.v3_sync    = {s_q.v3_sync[0], i_main_3v3_input};
    s_d.port_sync  = {s_q.port_sync[1:0], i_powered_port};
    case (s_q.st)
      ST_STRAP: begin
        // flash idle with chip select high, so the data-in pin shows the strap
        if (s_q.settle != `BSFL_STRAP_SETTLE) begin
          s_d.settle = s_q.settle + 4'h1;
        end else if (i_strap_ratio_valid) begin
          s_d.strap_level = s_q.miso_sync[1];
          s_d.mode        = strap.mode;
          s_d.cfg         = strap.cfg;
          s_d.st          = ST_DECIDE;
        end
      end
      ST_DECIDE: begin
        if (bus_only && (s_q.mode == MODE_NO_RESPONSE ||
                         s_q.mode == MODE_WAIT_3V3_INT ||
                         s_q.mode == MODE_WAIT_3V3_EXT)) begin
          s_d.st = ST_WAIT3V3;
        end else begin
          s_d.st = ST_START;
        end
      end
      ST_WAIT3V3: begin
        if (!bus_only) begin
          s_d.st = ST_START;
        end
      end
      ST_START: begin
        if (i_alt_cfg_valid) begin
          s_d.sw_sel = i_alt_switch_sel;
          s_d.loaded = 1'b1;
          s_d.st     = ST_RUN;
        end else begin
          s_d.cs_b = 1'b0;
          spi_go   = 1'b1;
          spi_tx   = cmd_byte(16'h0000);
          s_d.idx  = 16'h0000;
          s_d.st   = ST_CMD;
        end
      end
      ST_CMD: begin
        if (spi_done) begin
          spi_go = 1'b1;
          if (s_q.idx == `BSFL_CMD_LAST) begin
            s_d.idx = 16'h0000;
            s_d.st  = ST_DATA;
          end else begin
            s_d.idx = s_q.idx + 16'h0001;
            spi_tx  = cmd_byte(s_q.idx + 16'h0001);
          end
        end
      end
      ST_DATA: begin
        if (spi_done) begin
          if (s_q.idx == `BSFL_IDX_MAGIC && spi_rx != `BSFL_MAGIC) begin
            s_d.cs_b = 1'b1;
            s_d.st   = ST_FAIL;
          end else begin
            if (s_q.idx == `BSFL_IDX_SWSEL) begin
              s_d.sw_sel = spi_rx[1:0];
            end else if (s_q.idx != `BSFL_IDX_MAGIC) begin
              s_d.load_data  = spi_rx;
              s_d.load_valid = 1'b1;
            end
            if (s_q.idx == `BSFL_BUNDLE_LAST) begin
              s_d.cs_b   = 1'b1;
              s_d.loaded = 1'b1;
              s_d.st     = ST_RUN;
            end else begin
              s_d.idx = s_q.idx + 16'h0001;
              spi_go  = 1'b1;
            end
          end
        end
      end
      ST_FAIL: begin
        // infinite wait keeps retrying; the alternate path may still arrive
        if (s_q.cfg == CFG_INFINITE_WAIT) begin
          s_d.st = ST_START;
        end else begin
          s_d.fallback = 1'b1;
          s_d.st       = ST_RUN;
        end
      end
      ST_RUN: begin
        s_d.st = ST_RUN;
      end
      default: begin
        s_d.st = ST_STRAP;
      end
    endcase
    s_d.path_int    = int_en;
    s_d.path_ext    = ext_en;
    s_d.ports_en    = (s_d.st == ST_RUN) && !s_d.fallback;
    s_d.legacy_sink = s_d.fallback && bus_only;
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s_q      <= '0;
      s_q.cs_b <= 1'b1;
      s_q.st   <= ST_STRAP;
    end else begin
      s_q <= s_d;
    end
  end

  // data-in strap pin doubles as the flash return line once straps are held
  bsfl_spi_byte u_spi (
    .i_mclk         (i_mclk),
    .i_rst_b        (i_rst_b),
    .i_start        (spi_go),
    .i_tx_byte      (spi_tx),
    .i_data_in_sync (s_q.miso_sync[1]),
    .o_busy         (spi_busy),
    .o_done         (spi_done),
    .o_rx_byte      (spi_rx),
    .o_sck          (o_flash_clk),
    .o_data_out     (o_flash_data_out)
  );

  assign o_flash_cs_b               = s_q.cs_b;
  assign o_load_data                = s_q.load_data;
  assign o_load_valid               = s_q.load_valid;
  assign o_mode                     = s_q.mode;
  assign o_cfg                      = s_q.cfg;
  assign o_boot_done                = (s_q.st == ST_RUN) && !spi_busy;
  assign o_cfg_loaded               = s_q.loaded;
  assign o_fallback                 = s_q.fallback;
  assign o_high_voltage_path_int_en = s_q.path_int;
  assign o_high_voltage_path_ext_en = s_q.path_ext;
  assign o_ports_en                 = s_q.ports_en;
  assign o_legacy_sink              = s_q.legacy_sink;

endmodule : bsfl_boot_loader

`default_nettype wire

// *** logic/bsfl_spi_byte.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "bsfl_defs.svh"

module bsfl_spi_byte
  import bsfl_pkg::*;
(
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst_b,
  // byte request
  input  wire logic       i_start,
  input  wire logic [7:0] i_tx_byte,
  input  wire logic       i_data_in_sync,
  // byte answer
  output logic            o_busy,
  output logic            o_done,
  output logic [7:0]      o_rx_byte,
  // flash pins
  output logic            o_sck,
  output logic            o_data_out
);

  localparam logic [3:0] HALF_LAST = 4'(`BSFL_HALF_CYC - 1);

  bsfl_spi_s s_q;
  bsfl_spi_s s_d;

  always_comb begin
    s_d      = s_q;
    s_d.done = 1'b0;
    if (!s_q.busy) begin
      s_d.sck = 1'b0;
      if (i_start) begin
        s_d.busy = 1'b1;
        s_d.sh   = i_tx_byte;
        s_d.mosi = i_tx_byte[7];
        s_d.div  = 4'h0;
        s_d.bits = 3'h0;
      end
    end else if (s_q.div == HALF_LAST) begin
      s_d.div = 4'h0;
      if (!s_q.sck) begin
        s_d.sck = 1'b1;
        s_d.rx  = {s_q.rx[6:0], i_data_in_sync};
      end else begin
        s_d.sck = 1'b0;
        if (s_q.bits == 3'h7) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end else begin
          s_d.bits = s_q.bits + 3'h1;
          s_d.sh   = {s_q.sh[6:0], 1'b0};
          s_d.mosi = s_q.sh[6];
        end
      end
    end else begin
      s_d.div = s_q.div + 4'h1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rst_b) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign o_busy     = s_q.busy;
  assign o_done     = s_q.done;
  assign o_rx_byte  = s_q.rx;
  assign o_sck      = s_q.sck;
  assign o_data_out = s_q.mosi;

endmodule : bsfl_spi_byte

`default_nettype wire

// *** sim/bsfl_boot_loader_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module bsfl_boot_loader_properties
  import bsfl_pkg::*;
(
  // clock and reset
  input wire logic       i_mclk,
  input wire logic       i_rst_b,
  // flash pins
  input wire logic       o_flash_clk,
  input wire logic       o_flash_cs_b,
  input wire logic       o_flash_data_out,
  // status and power path
  input wire logic       o_load_valid,
  input wire bsfl_mode_e o_mode,
  input wire logic       o_boot_done,
  input wire logic       o_cfg_loaded,
  input wire logic       o_fallback,
  input wire logic [1:0] o_high_voltage_path_int_en,
  input wire logic [1:0] o_high_voltage_path_ext_en,
  input wire logic       o_ports_en
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_b);
  chk_clk_idle_low: assert property (o_flash_cs_b |-> !o_flash_clk)
    else $error("serial clock high while deselected");
  chk_first_bit: assert property ($fell(o_flash_cs_b) |-> !o_flash_data_out)
    else $error("first command bit not shown with select");
  chk_first_rise: assert property ($fell(o_flash_cs_b) |-> (!o_flash_clk)[*6] ##1 o_flash_clk)
    else $error("first serial clock rise misplaced");
  chk_clk_high_half: assert property ($rose(o_flash_clk) |-> o_flash_clk[*6] ##1 !o_flash_clk)
    else $error("serial clock high half wrong");
  chk_data_on_fall: assert property (o_flash_clk |-> $stable(o_flash_data_out))
    else $error("data changed while serial clock high");
  chk_load_pulse: assert property (o_load_valid |=> !o_load_valid)
    else $error("load strobe longer than one cycle");
  chk_noresp_open: assert property ((o_mode == MODE_NO_RESPONSE && !o_cfg_loaded)
    |-> (o_high_voltage_path_int_en | o_high_voltage_path_ext_en) == 2'h0)
    else $error("switch closed in no-response mode");
  chk_safe_ports_off: assert property (o_fallback |-> !o_ports_en)
    else $error("ports enabled under safe fallback");
  chk_strap_held: assert property (o_boot_done |=> $stable(o_mode))
    else $error("decoded mode changed after boot");
endmodule : bsfl_boot_loader_properties
bind bsfl_boot_loader bsfl_boot_loader_properties i_props (.i_mclk, .i_rst_b, .o_flash_clk,
  .o_flash_cs_b, .o_flash_data_out, .o_load_valid, .o_mode, .o_boot_done, .o_cfg_loaded,
  .o_fallback, .o_high_voltage_path_int_en, .o_high_voltage_path_ext_en, .o_ports_en);
`default_nettype wire

// *** sim/bsfl_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module bsfl_flash_model (
  // flash pins
  input  wire logic       i_sck,
  input  wire logic       i_cs_b,
  input  wire logic       i_din,
  output logic            o_dout,
  // strap resistor and content
  input  wire logic       i_strap,
  input  wire logic [7:0] i_magic,
  input  wire logic [1:0] i_sw
);
  int unsigned n = 0;
  logic [31:0] cmd = 32'h0;
  logic        drv = 1'b0;
  logic [7:0]  b;
  // deselected: only the strap resistor holds the line
  assign o_dout = i_cs_b ? i_strap : drv;
  always @(negedge i_cs_b) begin
    n = 0;
  end
  // capture on rising edge at any rate the device uses
  always @(posedge i_sck) begin
    if (!i_cs_b) begin
      if (n < 32) cmd = {cmd[30:0], i_din};
      n = n + 1;
    end
  end
  // shift on falling edge; byte 0 is the magic, byte 1 the switch choice, then the byte index
  always @(negedge i_sck) begin
    if (!i_cs_b && n >= 32) begin
      b = ((n - 32) / 8 == 0) ? i_magic : ((n - 32) / 8 == 1) ? {6'h00, i_sw} : 8'((n - 32) / 8);
      drv = b[7 - (n - 32) % 8];
    end
  end
endmodule : bsfl_flash_model
`default_nettype wire

// *** sim/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bsfl_pkg::*;
  logic       i_mclk = 1'b0;
  logic       i_rst_b = 1'b0;
  logic [6:0] ratio = 7'h00;
  logic       v3 = 1'b0;
  logic [1:0] port = 2'h1;
  logic       alt = 1'b0;
  logic       strap = 1'b1;
  logic       rv = 1'b1;
  logic [7:0] magic = 8'ha5;
  wire        sck, cs_b, dout, din, lvalid, done, loaded, fb, pen, lsink;
  wire  [7:0] ldata;
  wire  [1:0] int_en, ext_en;
  bsfl_mode_e mode;
  bsfl_cfg_e  cfg;
  int         err_count = 0;
  int         n_compared = 0;
  int         ncs = 0;
  int         cyc = 0;
  logic [7:0] q[$];

  bsfl_boot_loader i_dut (.i_mclk(i_mclk), .i_rst_b(i_rst_b), .i_strap_ratio(ratio),
    .i_strap_ratio_valid(rv), .i_main_3v3_input(v3), .i_powered_port(port),
    .i_alt_cfg_valid(alt), .i_alt_switch_sel(2'h3), .i_flash_data_in(din),
    .o_flash_clk(sck), .o_flash_cs_b(cs_b), .o_flash_data_out(dout), .o_load_data(ldata),
    .o_load_valid(lvalid), .o_mode(mode), .o_cfg(cfg), .o_boot_done(done),
    .o_cfg_loaded(loaded), .o_fallback(fb), .o_high_voltage_path_int_en(int_en),
    .o_high_voltage_path_ext_en(ext_en), .o_ports_en(pen), .o_legacy_sink(lsink));
  bsfl_flash_model i_flash (.i_sck(sck), .i_cs_b(cs_b), .i_din(dout), .o_dout(din),
    .i_strap(strap), .i_magic(magic), .i_sw(2'h2));

  initial forever #4 i_mclk = ~i_mclk;
  always @(negedge i_mclk) if (lvalid === 1'b1) q.push_back(ldata);
  always @(negedge cs_b) ncs++;
  // longest path is two full loads, about 50k cycles
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 95000) begin
      err_count++;
      end_of_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    n_compared++;
    if (s !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic boot(input logic s, input logic [6:0] r, input logic v, input logic a);
    @(negedge i_mclk);
    i_rst_b = 1'b0;
    strap = s;
    ratio = r;
    v3 = v;
    alt = a;
    repeat (8) @(negedge i_mclk);
    q.delete();
    ncs = 0;
    i_rst_b = 1'b1;
  endtask : boot

  task automatic wait_done();
    for (int k = 0; k < 40000 && done !== 1'b1; k++) @(negedge i_mclk);
    // switch enables follow the loaded flag one register stage later
    repeat (2) @(negedge i_mclk);
  endtask : wait_done

  task automatic t_decode();
    logic [13:0] t [15] = '{{1'b1, 7'h0a, 3'h0, 3'h0}, {1'b1, 7'h19, 3'h1, 3'h0},
      {1'b1, 7'h23, 3'h3, 3'h1}, {1'b1, 7'h2d, 3'h2, 3'h0}, {1'b1, 7'h37, 3'h4, 3'h1},
      {1'b1, 7'h50, 3'h5, 3'h0}, {1'b1, 7'h13, 3'h0, 3'h0}, {1'b0, 7'h05, 3'h0, 3'h1},
      {1'b0, 7'h2d, 3'h5, 3'h2}, {1'b0, 7'h4a, 3'h5, 3'h4}, {1'b0, 7'h5f, 3'h5, 3'h3},
      {1'b0, 7'h41, 3'h0, 3'h1}, {1'b0, 7'h23, 3'h3, 3'h1}, {1'b0, 7'h37, 3'h4, 3'h1},
      {1'b0, 7'h59, 3'h0, 3'h1}};
    rv = 1'b0;
    boot(1'b0, 7'h2d, 1'b1, 1'b1);
    repeat (20) @(negedge i_mclk);
    chk("strap unsampled", 8'h00, 8'(loaded));
    rv = 1'b1;
    repeat (20) @(negedge i_mclk);
    chk("late strap mode", 8'h05, 8'(mode));
    strap = 1'b1;
    repeat (20) @(negedge i_mclk);
    chk("strap held", 8'h05, 8'(mode));
    foreach (t[i]) begin
      boot(t[i][13], t[i][12:6], 1'b1, 1'b1);
      repeat (20) @(negedge i_mclk);
      chk("mode", 8'(t[i][5:3]), 8'(mode));
      chk("cfg", 8'(t[i][2:0]), 8'(cfg));
    end
    chk("alt loaded", 8'h01, 8'(loaded));
    chk("alt flash idle", 8'h00, 8'(ncs));
  endtask : t_decode

  task automatic t_load();
    boot(1'b1, 7'h50, 1'b0, 1'b0);
    wait_done();
    chk("read cmd", 8'h03, i_flash.cmd[31:24]);
    chk("read addr", 8'h00, 8'(|i_flash.cmd[23:0]));
    chk("payload count", 8'hfe, 8'(q.size()));
    foreach (q[i]) chk("payload", 8'(i + 2), q[i]);
    chk("ext switch", 8'h01, 8'(ext_en));
    chk("int switch", 8'h00, 8'(int_en));
    chk("ports", 8'h01, 8'(pen));
  endtask : t_load

  task automatic t_fail();
    magic = 8'h00;
    boot(1'b1, 7'h50, 1'b0, 1'b0);
    wait_done();
    chk("fallback", 8'h01, 8'(fb));
    chk("ports off", 8'h00, 8'(pen));
    chk("legacy sink", 8'h01, 8'(lsink));
    chk("no payload", 8'h00, 8'(q.size()));
    magic = 8'ha5;
  endtask : t_fail

  task automatic t_wait(input logic [6:0] r, input logic [3:0] e);
    port = 2'h2;
    boot(1'b1, r, 1'b0, 1'b1);
    repeat (40) @(negedge i_mclk);
    chk("held done", 8'h00, 8'(done));
    chk("held switch", 8'(e), 8'({ext_en, int_en}));
    v3 = 1'b1;
    wait_done();
    chk("resumed", 8'h01, 8'(loaded));
    chk("alt switch", 8'h0a, 8'({ext_en, int_en}));
    port = 2'h1;
  endtask : t_wait

  task automatic t_retry();
    magic = 8'h00;
    boot(1'b1, 7'h23, 1'b0, 1'b0);
    repeat (1500) @(negedge i_mclk);
    chk("retries", 8'h01, 8'(ncs >= 2));
    chk("still booting", 8'h00, 8'(done));
    chk("int switch", 8'h01, 8'(int_en));
    magic = 8'ha5;
    wait_done();
    chk("late load", 8'h01, 8'(loaded));
  endtask : t_retry

  task automatic end_of_test();
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  initial begin
    t_decode();
    t_load();
    t_fail();
    t_wait(7'h19, 4'h2);
    t_wait(7'h2d, 4'h8);
    t_wait(7'h0a, 4'h0);
    t_retry();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
